// File: pkg/wake_mon_pkg.sv
// constants for the activity wake-up monitor
package wake_mon_pkg;
   // register offsets
   localparam logic [7:0] dma_enable_off = 8'hE4;
   localparam logic [7:0] area_enable_off = 8'hE5;
   localparam logic [7:0] range_low_off = 8'hE6;
   localparam logic [7:0] range_cfg_off = 8'hE7;
   localparam logic [7:0] strobe_ctrl_off = 8'hEE;
   localparam logic [7:0] status_off = 8'hF0;
   // reset value and write masks
   localparam logic [7:0] reg_reset = 8'h00;
   localparam logic [7:0] dma_valid_mask = 8'hEF;
   localparam logic [7:0] cfg_valid_mask = 8'h73;
   // field positions
   localparam int range_bit = 7;
   localparam int video_bit = 6;
   localparam int display_io_bit = 5;
   localparam int disk_io_bit = 4;
   localparam int floppy_io_bit = 3;
   localparam int keyb_io_bit = 2;
   localparam int claim_bit = 1;
   localparam int master_bit = 0;
   localparam int bm_strobe_bit = 7;
   localparam int dma_strobe_bit = 6;
   localparam int mask_lsb = 4;
   localparam int mask_w = 3;
   localparam int hi_lsb = 0;
   localparam int hi_w = 2;
   // fixed areas
   localparam logic [31:0] video_lo = 32'h000A_0000;
   localparam logic [31:0] video_hi = 32'h000B_FFFF;
   localparam logic [9:0] disp_lo = 10'h3B0;
   localparam logic [9:0] disp_hi = 10'h3DF;
   localparam logic [9:0] disk_lo = 10'h1F0;
   localparam logic [9:0] disk_hi = 10'h1F7;
   localparam logic [9:0] disk_ctl = 10'h3F6;
   localparam logic [9:0] floppy_port = 10'h3F5;
   localparam logic [9:0] keyb_data = 10'h060;
   localparam logic [9:0] keyb_stat = 10'h064;
endpackage : wake_mon_pkg

// File: core/port_range_match.sv
// masked 10-bit i/o port range comparator
`timescale 1ns/1ps
`default_nettype none
module port_range_match #(
   parameter int addr_w = 10,
   parameter int mask_w = 3
) (
   // compare inputs
   input wire logic [addr_w-1:0] port_i,
   input wire logic [addr_w-1:0] base_i,
   input wire logic [mask_w-1:0] mask_n_i,
   // result
   output logic hit_o
);
   logic [addr_w-1:0] care;
   always_comb begin
      for (int i = 0; i < addr_w; i++) begin
         care[i] = (i >= int'(mask_n_i)); // [RULE15]
      end
   end
   assign hit_o = (((port_i ^ base_i) & care) == '0); // [RULE13]
endmodule : port_range_match
`default_nettype wire

// File: core/activity_wakeup_monitor.sv
// activity monitor producing timer reloads and wake-up strobes
//
// Notes on behaviour
// [RULE1] power saving: enabled dma request reloads green event timer; bit 4 reserved
// [RULE2] power saving: enabled dma request pulses strobe when dma strobe enable set
// [RULE3] normal mode: enabled dma request only reloads the timer
// [RULE4] power saving: range hit with bit 7 gives wake-up, reload and strobe
// [RULE5] range from low byte, high bits, mask; normal mode hit only reloads
// [RULE6] power saving: enabled fixed area access gives wake-up, reload and strobe
// [RULE7] normal mode: enabled fixed area access only reloads the timer
// [RULE8] areas: video memory, display i/o, disk i/o, floppy port, keyboard ports
// [RULE9] power saving: device claim with bit 1 gives wake-up, reload, strobe
// [RULE10] normal mode: device claim with bit 1 only reloads
// [RULE11] power saving: master request needs bit 0 and bus master strobe enable
// [RULE12] normal mode: master request with bit 0 only reloads
// [RULE13] range low byte holds port address bits 7..0
// [RULE14] two-bit field supplies port address bits 9..8
// [RULE15] mask field excludes lowest n address bits from comparison
// [RULE16] dma strobe enable bit lets dma requests pulse the strobe
// [RULE17] bus master strobe enable lets master requests pulse the strobe
// [RULE18] i/o hits need i/o cycles, video needs memory cycles; one-cycle pulses
// [RULE19] all enables and range address clear on reset
`timescale 1ns/1ps
`default_nettype none
module activity_wakeup_monitor #(
   parameter int dma_w = 8,
   parameter int addr_w = 32
) (
   // clock, reset, enable
   input wire logic sys_clk_i,
   input wire logic nrst_i,
   input wire logic ce_i,
   // register port
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [7:0] reg_rdata_o,
   // mode from power management
   input wire logic power_saving_i,
   // monitored bus activity (pins)
   input wire logic [dma_w-1:0] dma_req_i,
   input wire logic [addr_w-1:0] bus_addr_i,
   input wire logic io_cycle_i,
   input wire logic mem_cycle_i,
   input wire logic local_device_claim_n_i,
   input wire logic local_master_request_n_i,
   // results
   output logic timer_reload_o,
   output logic wakeup_event_o,
   output logic power_port_strobe_o
);
   // register state
   logic [7:0] dma_en_ff;
   logic [7:0] area_en_ff;
   logic [7:0] range_low_ff;
   logic [7:0] range_cfg_ff;
   logic dma_strobe_enable_ff;
   logic bus_master_strobe_enable_ff;
   logic woke_flag_ff;
   logic [7:0] rdata_ff;
   // pin synchronisers: stage one only feeds stage two
   logic [dma_w-1:0] dma_s1_ff, dma_s2_ff, dma_prev_ff;
   logic claim_s1_ff, claim_s2_ff, claim_prev_ff;
   logic mreq_s1_ff, mreq_s2_ff, mreq_prev_ff;
   logic io_s1_ff, io_s2_ff, io_prev_ff;
   logic mem_s1_ff, mem_s2_ff, mem_prev_ff;
   logic [addr_w-1:0] addr_s1_ff, addr_s2_ff;
   // outputs
   logic reload_ff, wake_ff, strobe_ff;

   // write decode
   wire wr_dma = reg_wr_i && (reg_addr_i == wake_mon_pkg::dma_enable_off);
   wire wr_area = reg_wr_i && (reg_addr_i == wake_mon_pkg::area_enable_off);
   wire wr_low = reg_wr_i && (reg_addr_i == wake_mon_pkg::range_low_off);
   wire wr_cfg = reg_wr_i && (reg_addr_i == wake_mon_pkg::range_cfg_off);
   wire wr_ctl = reg_wr_i && (reg_addr_i == wake_mon_pkg::strobe_ctrl_off);
   wire rd_ctl = reg_rd_i && (reg_addr_i == wake_mon_pkg::strobe_ctrl_off);

   // read mux; strobe control reads back the woke flag in bit 7, bit 6 is write only
   wire [7:0] ctl_view = {woke_flag_ff, 7'h00};
   wire [7:0] rd_mux =
      (reg_addr_i == wake_mon_pkg::dma_enable_off) ? dma_en_ff :
      (reg_addr_i == wake_mon_pkg::area_enable_off) ? area_en_ff :
      (reg_addr_i == wake_mon_pkg::range_low_off) ? range_low_ff :
      (reg_addr_i == wake_mon_pkg::range_cfg_off) ? range_cfg_ff :
      (reg_addr_i == wake_mon_pkg::strobe_ctrl_off) ? ctl_view :
      (reg_addr_i == wake_mon_pkg::status_off) ?
         {5'h00, strobe_ff, wake_ff, reload_ff} : wake_mon_pkg::reg_reset;

   // edge detection on synchronised levels so each detection is one pulse
   wire [dma_w-1:0] dma_rise = dma_s2_ff & ~dma_prev_ff;
   wire claim_rise = claim_s2_ff & ~claim_prev_ff;
   wire mreq_rise = mreq_s2_ff & ~mreq_prev_ff;
   wire io_start = io_s2_ff & ~io_prev_ff;
   wire mem_start = mem_s2_ff & ~mem_prev_ff;
   wire [9:0] port = addr_s2_ff[9:0];

   // programmable range
   wire range_hit_raw;
   port_range_match #(
      .addr_w(10),
      .mask_w(wake_mon_pkg::mask_w)
   ) u_range (
      .port_i(port),
      .base_i({range_cfg_ff[wake_mon_pkg::hi_lsb +: wake_mon_pkg::hi_w], range_low_ff}), // [RULE14]
      .mask_n_i(range_cfg_ff[wake_mon_pkg::mask_lsb +: wake_mon_pkg::mask_w]),
      .hit_o(range_hit_raw)
   );

   // fixed areas
   wire video_hit = mem_start && (addr_s2_ff >= wake_mon_pkg::video_lo)
      && (addr_s2_ff <= wake_mon_pkg::video_hi); // [RULE8] [RULE18]
   wire disp_hit = io_start && (port >= wake_mon_pkg::disp_lo) && (port <= wake_mon_pkg::disp_hi);
   wire disk_hit = io_start && (((port >= wake_mon_pkg::disk_lo) && (port <= wake_mon_pkg::disk_hi))
      || (port == wake_mon_pkg::disk_ctl)); // [RULE8]
   wire flop_hit = io_start && (port == wake_mon_pkg::floppy_port);
   wire keyb_hit = io_start && ((port == wake_mon_pkg::keyb_data)
      || (port == wake_mon_pkg::keyb_stat)); // [RULE8]

   // qualified sources
   wire dma_act = |(dma_rise & dma_en_ff); // [RULE1] [RULE3]
   wire range_act = io_start && range_hit_raw && area_en_ff[wake_mon_pkg::range_bit]; // [RULE5]
   wire area_act = (video_hit && area_en_ff[wake_mon_pkg::video_bit])
      || (disp_hit && area_en_ff[wake_mon_pkg::display_io_bit])
      || (disk_hit && area_en_ff[wake_mon_pkg::disk_io_bit])
      || (flop_hit && area_en_ff[wake_mon_pkg::floppy_io_bit])
      || (keyb_hit && area_en_ff[wake_mon_pkg::keyb_io_bit]); // [RULE6] [RULE7]
   wire claim_act = claim_rise && area_en_ff[wake_mon_pkg::claim_bit]; // [RULE9] [RULE10]
   wire mreq_act = mreq_rise && area_en_ff[wake_mon_pkg::master_bit]; // [RULE12]

   // wake-up events only in power saving mode; normal mode only reloads
   wire wake_any = power_saving_i && (range_act || area_act || claim_act
      || (mreq_act && bus_master_strobe_enable_ff)); // [RULE4] [RULE11] [RULE17]
   wire dma_strobe = power_saving_i && dma_act && dma_strobe_enable_ff; // [RULE2] [RULE16]
   wire nxt_reload = dma_act || range_act || area_act || claim_act || mreq_act;
   wire nxt_strobe = wake_any || dma_strobe;
   // woke flag: a new wake wins over the clear-on-read
   wire nxt_woke = wake_any || (woke_flag_ff && !rd_ctl);

   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         dma_s1_ff <= '0;
         dma_s2_ff <= '0;
         dma_prev_ff <= '0;
         {claim_s1_ff, claim_s2_ff, claim_prev_ff} <= 3'h0;
         {mreq_s1_ff, mreq_s2_ff, mreq_prev_ff} <= 3'h0;
         {io_s1_ff, io_s2_ff, io_prev_ff} <= 3'h0;
         {mem_s1_ff, mem_s2_ff, mem_prev_ff} <= 3'h0;
         addr_s1_ff <= '0;
         addr_s2_ff <= '0;
      end else if (ce_i) begin
         dma_s1_ff <= dma_req_i;
         dma_s2_ff <= dma_s1_ff;
         dma_prev_ff <= dma_s2_ff;
         claim_s1_ff <= ~local_device_claim_n_i;
         claim_s2_ff <= claim_s1_ff;
         claim_prev_ff <= claim_s2_ff;
         mreq_s1_ff <= ~local_master_request_n_i;
         mreq_s2_ff <= mreq_s1_ff;
         mreq_prev_ff <= mreq_s2_ff;
         io_s1_ff <= io_cycle_i;
         io_s2_ff <= io_s1_ff;
         io_prev_ff <= io_s2_ff;
         mem_s1_ff <= mem_cycle_i;
         mem_s2_ff <= mem_s1_ff;
         mem_prev_ff <= mem_s2_ff;
         addr_s1_ff <= bus_addr_i;
         addr_s2_ff <= addr_s1_ff;
      end
   end

   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         dma_en_ff <= wake_mon_pkg::reg_reset; // [RULE19]
         area_en_ff <= wake_mon_pkg::reg_reset;
         range_low_ff <= wake_mon_pkg::reg_reset;
         range_cfg_ff <= wake_mon_pkg::reg_reset;
         dma_strobe_enable_ff <= 1'b0;
         bus_master_strobe_enable_ff <= 1'b0;
      end else if (ce_i) begin
         if (wr_dma) dma_en_ff <= reg_wdata_i & wake_mon_pkg::dma_valid_mask; // [RULE1]
         if (wr_area) area_en_ff <= reg_wdata_i;
         if (wr_low) range_low_ff <= reg_wdata_i; // [RULE13]
         if (wr_cfg) range_cfg_ff <= reg_wdata_i & wake_mon_pkg::cfg_valid_mask;
         if (wr_ctl) begin
            dma_strobe_enable_ff <= reg_wdata_i[wake_mon_pkg::dma_strobe_bit]; // [RULE16]
            bus_master_strobe_enable_ff <= reg_wdata_i[wake_mon_pkg::bm_strobe_bit]; // [RULE17]
         end
      end
   end

   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         reload_ff <= 1'b0;
         wake_ff <= 1'b0;
         strobe_ff <= 1'b0;
         woke_flag_ff <= 1'b0;
         rdata_ff <= wake_mon_pkg::reg_reset;
      end else if (ce_i) begin
         reload_ff <= nxt_reload; // [RULE18]
         wake_ff <= wake_any;
         strobe_ff <= nxt_strobe;
         woke_flag_ff <= nxt_woke;
         rdata_ff <= reg_rd_i ? rd_mux : wake_mon_pkg::reg_reset;
      end
   end

   assign timer_reload_o = reload_ff;
   assign wakeup_event_o = wake_ff;
   assign power_port_strobe_o = strobe_ff;
   assign reg_rdata_o = rdata_ff;

   // checks
   sequence dma_evt_s;
      ce_i && dma_act;
   endsequence
   sequence normal_act_s;
      ce_i && !power_saving_i && nxt_reload;
   endsequence

   chk_dma_reload: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
      dma_evt_s |=> timer_reload_o) // [RULE1]
      else $error("dma request did not reload timer");
   chk_dma_strobe_gate: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
      dma_evt_s and power_saving_i && !dma_strobe_enable_ff && !wake_any
      |=> !power_port_strobe_o) // [RULE2]
      else $error("dma strobe without enable");
   chk_normal_nostrobe: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
      normal_act_s |=> timer_reload_o && !power_port_strobe_o) // [RULE3]
      else $error("normal mode produced a strobe");
   chk_wake_pair: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
      wakeup_event_o |-> timer_reload_o && power_port_strobe_o) // [RULE4]
      else $error("wake-up without reload and strobe");
   chk_area_wake: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
      ce_i && power_saving_i && area_act |=> wakeup_event_o) // [RULE6]
      else $error("area access missed wake-up");
   chk_claim_wake: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
      ce_i && power_saving_i && claim_act |=> power_port_strobe_o) // [RULE9]
      else $error("claim missed strobe");
   chk_master_gate: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
      ce_i && !bus_master_strobe_enable_ff && !range_act && !area_act && !claim_act
      && !dma_strobe |=> !power_port_strobe_o) // [RULE11]
      else $error("master strobe without enable");
   chk_pulse_single: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
      ce_i && wakeup_event_o && !wake_any |=> !wakeup_event_o) // [RULE18]
      else $error("wake pulse stretched");
   chk_reset_clear: assert property (@(posedge sys_clk_i)
      $rose(nrst_i) |-> dma_en_ff == 8'h00 && area_en_ff == 8'h00) // [RULE19]
      else $error("enables not cleared by reset");
endmodule : activity_wakeup_monitor
`default_nettype wire

// File: verif/bus_agent_model.sv
// far-side model: dma requesters, bus agents and local masters
`timescale 1ns/1ps
`default_nettype none
module bus_agent_model (
   // clock
   input wire logic clk_i,
   // driven pins
   output logic [7:0] dma_req_o,
   output logic [31:0] bus_addr_o,
   output logic io_cycle_o,
   output logic mem_cycle_o,
   output logic claim_n_o,
   output logic master_n_o
);
   initial begin
      dma_req_o = 8'h00;
      bus_addr_o = 32'h0000_0000;
      io_cycle_o = 1'b0;
      mem_cycle_o = 1'b0;
      claim_n_o = 1'b1;
      master_n_o = 1'b1;
   end
   // kind: 0 dma line a[2:0], 1 io cycle, 2 memory cycle, 3 claim, 4 master request
   task automatic fire(input int k, input logic [31:0] a);
      @(posedge clk_i);
      bus_addr_o <= a;
      io_cycle_o <= (k == 1);
      mem_cycle_o <= (k == 2);
      claim_n_o <= (k != 3);
      master_n_o <= (k != 4);
      dma_req_o <= (k == 0) ? (8'h01 << a[2:0]) : 8'h00;
      // held long enough for the two-stage synchroniser
      repeat (4) @(posedge clk_i);
      // a released bus keeps no stale address: show its inverse
      bus_addr_o <= ~a;
      io_cycle_o <= 1'b0;
      mem_cycle_o <= 1'b0;
      claim_n_o <= 1'b1;
      master_n_o <= 1'b1;
      dma_req_o <= 8'h00;
   endtask : fire
endmodule : bus_agent_model
`default_nettype wire

// File: verif/tb.sv
// self-checking bench for the activity wake-up monitor
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin mismatches++; \
   $display("Error %s expected %h seen %h", n, e, g); end end
module tb;
   logic sys_clk_i = 1'b0;
   logic nrst_i = 1'b0;
   logic ce_i = 1'b0;
   logic [7:0] reg_addr_i = 8'h00;
   logic [7:0] reg_wdata_i = 8'h00;
   logic reg_wr_i = 1'b0;
   logic reg_rd_i = 1'b0;
   logic power_saving_i = 1'b0;
   logic [7:0] reg_rdata_o, dma_req;
   logic [31:0] bus_addr;
   logic io_cycle, mem_cycle, claim_n, master_n;
   logic timer_reload_o, wakeup_event_o, power_port_strobe_o;
   int mismatches = 0;
   int samples_checked = 0;
   int n_rl = 0, n_wk = 0, n_st = 0, cycles = 0;
   int ab[9] = '{6, 5, 5, 4, 4, 4, 3, 2, 2};
   logic [31:0] aa[9] = '{32'h000A_0000, 32'h0000_03B0, 32'h0000_03DF, 32'h0000_01F0,
      32'h0000_01F7, 32'h0000_03F6, 32'h0000_03F5, 32'h0000_0060, 32'h0000_0064};
   always #2 sys_clk_i = ~sys_clk_i;
   bus_agent_model agent (.clk_i(sys_clk_i), .dma_req_o(dma_req), .bus_addr_o(bus_addr),
      .io_cycle_o(io_cycle), .mem_cycle_o(mem_cycle), .claim_n_o(claim_n), .master_n_o(master_n));
   activity_wakeup_monitor uut (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .ce_i(ce_i),
      .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
      .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .power_saving_i(power_saving_i),
      .dma_req_i(dma_req), .bus_addr_i(bus_addr), .io_cycle_i(io_cycle), .mem_cycle_i(mem_cycle),
      .local_device_claim_n_i(claim_n), .local_master_request_n_i(master_n),
      .timer_reload_o(timer_reload_o), .wakeup_event_o(wakeup_event_o),
      .power_port_strobe_o(power_port_strobe_o));
   // pulse counters; a held level must give exactly one pulse per detection
   always @(posedge sys_clk_i) begin
      cycles <= cycles + 1;
      if (timer_reload_o === 1'b1) n_rl <= n_rl + 1;
      if (wakeup_event_o === 1'b1) n_wk <= n_wk + 1;
      if (power_port_strobe_o === 1'b1) n_st <= n_st + 1;
      // an unknown pulse would slip past the counters, so flag it here
      if (nrst_i && $isunknown({timer_reload_o, wakeup_event_o, power_port_strobe_o})) begin
         mismatches++;
         $display("Error pulse_outputs expected known seen %b",
            {timer_reload_o, wakeup_event_o, power_port_strobe_o});
      end
      if (cycles == 20000) begin
         mismatches++;
         report_and_stop();
      end
   end
   task automatic report_and_stop();
      $display("checked %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : report_and_stop
   // one idle edge after each strobe so no signal is driven twice in a step
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= 1'b1;
      @(posedge sys_clk_i);
      reg_wr_i <= 1'b0;
      @(posedge sys_clk_i);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge sys_clk_i);
      reg_rd_i <= 1'b0;
      #1 `CHK("reg_rdata_o", e, reg_rdata_o)
      @(posedge sys_clk_i);
   endtask : rd
   task automatic act(input int k, input logic [31:0] a, input int er, input int ew, input int es);
      int r0, w0, s0;
      r0 = n_rl;
      w0 = n_wk;
      s0 = n_st;
      agent.fire(k, a);
      repeat (8) @(posedge sys_clk_i);
      `CHK("timer_reload_o", er, n_rl - r0)
      `CHK("wakeup_event_o", ew, n_wk - w0)
      `CHK("power_port_strobe_o", es, n_st - s0)
   endtask : act
   task automatic areas();
      for (int i = 0; i < 9; i++) begin
         wr(8'hE5, 8'h01 << ab[i]);
         act((ab[i] == 6) ? 2 : 1, aa[i], 1, 0, 0);
         wr(8'hE5, 8'h7C & ~(8'h01 << ab[i]));
         act((ab[i] == 6) ? 2 : 1, aa[i], 0, 0, 0);
      end
      power_saving_i <= 1'b1;
      wr(8'hE5, 8'h7C);
      for (int i = 0; i < 9; i++) act((ab[i] == 6) ? 2 : 1, aa[i], 1, 1, 1);
      act(1, 32'h000A_0000, 0, 0, 0);
      act(2, 32'h0000_03B0, 0, 0, 0);
      act(1, 32'h0000_03E0, 0, 0, 0);
   endtask : areas
   task automatic ranges();
      wr(8'hE5, 8'h80);
      wr(8'hE6, 8'h34);
      wr(8'hE7, 8'h32);
      rd(8'hE7, 8'h32);
      act(1, 32'h0000_0237, 1, 1, 1);
      act(1, 32'h0000_0238, 0, 0, 0);
      act(2, 32'h0000_0234, 0, 0, 0);
      wr(8'hE7, 8'h72);
      act(1, 32'h0000_027F, 1, 1, 1);
      act(1, 32'h0000_0280, 0, 0, 0);
      power_saving_i <= 1'b0;
      wr(8'hE7, 8'h02);
      act(1, 32'h0000_0234, 1, 0, 0);
      act(1, 32'h0000_0235, 0, 0, 0);
      act(1, 32'h0000_0134, 0, 0, 0);
   endtask : ranges
   initial begin
      repeat (16) @(posedge sys_clk_i);
      nrst_i <= 1'b1;
      ce_i <= 1'b1;
      @(posedge sys_clk_i);
      rd(8'hE4, 8'h00);
      rd(8'hE5, 8'h00);
      rd(8'hE6, 8'h00);
      rd(8'h80, 8'h00);
      // a frozen block must ignore a write strobe
      ce_i <= 1'b0;
      wr(8'hE6, 8'hA5);
      ce_i <= 1'b1;
      rd(8'hE6, 8'h00);
      wr(8'hE4, 8'hFF);
      rd(8'hE4, 8'hEF);
      act(0, 32'h0000_0000, 1, 0, 0);
      act(0, 32'h0000_0004, 0, 0, 0);
      power_saving_i <= 1'b1;
      act(0, 32'h0000_0007, 1, 0, 0);
      wr(8'hEE, 8'h40);
      act(0, 32'h0000_0003, 1, 0, 1);
      power_saving_i <= 1'b0;
      act(0, 32'h0000_0005, 1, 0, 0);
      areas();
      ranges();
      wr(8'hE5, 8'h03);
      wr(8'hEE, 8'h00);
      act(3, 32'h0000_0000, 1, 0, 0);
      act(4, 32'h0000_0000, 1, 0, 0);
      power_saving_i <= 1'b1;
      act(3, 32'h0000_0000, 1, 1, 1);
      act(4, 32'h0000_0000, 1, 0, 0);
      wr(8'hEE, 8'h80);
      act(4, 32'h0000_0000, 1, 1, 1);
      wr(8'hE5, 8'h00);
      act(3, 32'h0000_0000, 0, 0, 0);
      // woke flag reads set once, then clears on that read
      rd(8'hEE, 8'h80);
      rd(8'hEE, 8'h00);
      // reset in mid-run must clear what software has written
      wr(8'hE5, 8'h83);
      nrst_i <= 1'b0;
      repeat (2) @(posedge sys_clk_i);
      nrst_i <= 1'b1;
      @(posedge sys_clk_i);
      rd(8'hE5, 8'h00);
      rd(8'hE7, 8'h00);
      report_and_stop();
   end
endmodule : tb
`default_nettype wire
